// >>> rtl/ccw_config_word.sv
// 96-bit configuration word: serial load, staged apply and decode to output controls
//
// Overview of operation
// - bit 61 high selects 2.5V control-pin thresholds, low selects 1.8V.
// - bit 60 low selects the 50-125 MHz vco band, high the 100-250 MHz band.
// - bit 58 low aligns outputs to the falling reference edge, high to the rising edge.
// - bits 56 down to 52 are the disable controls of banks one to five, mirroring the disable pins.
// - a bank runs only when its disable bit and its disable pin are both low.
// - disabled outputs are gated when the style pin or bit 59 is high, else tri-stated.
// - in gated disable bit 58 low stops true and feedback outputs high and complements low, high reverses.
// - bits 51 to 48 select feedback divide 1,2,3,4,5,6,8,10,12 for codes 0 to 8, others reserved.
// - two-bit output level fields sit at 47:46 down to 37:36 for banks one to five and feedback.
// - two-bit input interface fields sit at 35:34, 33:32 and 31:30 for ref zero, ref one, feedback.
// - input code 00 is differential, 01 is 2.5V single-ended, 11 is 1.8V single-ended, 10 reserved.
// - five-bit skew fields sit at 29:25 down to 4:0 for banks one to five and feedback.
// - skew code 00000 is zero skew, 10000 inverts, 10001 divides by two, 10010 by four, others zero.
`timescale 1ns/10ps
`default_nettype none
module ccw_config_word
    import ccw_pkg::*;
#(
    parameter int WORD_W = CCW_WORD_W
)
(
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // serial load port from the protocol engine
    input  wire ccw_pkg::ccw_serial_t ser_in,
    output logic                      ser_out,
    output logic                      load_error,
    // device pins
    input  wire logic                 disable_style_select,
    input  wire logic [4:0]           bank_output_disable,
    input  wire logic                 loop_enable_pin,
    // applied word readback
    output logic [95:0]               clock_configuration_word,
    // global controls
    output logic                      ctrl_pin_lvl_25,
    output logic                      vco_band_high,
    output logic                      sync_rising_edge,
    output logic                      loop_bypass,
    output logic                      reserved_nonzero,
    // feedback divide
    output logic [3:0]                fb_divide_ratio,
    output logic                      fb_divide_reserved,
    // input interfaces: reference_input_zero, reference_input_one, feedback
    output var ccw_pkg::ccw_inif_t    reference_input_zero_if,
    output var ccw_pkg::ccw_inif_t    reference_input_one_if,
    output var ccw_pkg::ccw_inif_t    feedback_input_if,
    // bank controls: index 0..4 banks one to five, index 5 feedback
    output var ccw_pkg::ccw_bank_ctl_t [5:0] bank_clock_output_ctl
);
    import ccw_pkg::*;

    // field extraction helpers
    function automatic logic [1:0] lvl_field(input logic [95:0] w, input int idx);
        lvl_field = w[CCW_LVL_HI_BIT - CCW_LVL_W*idx -: CCW_LVL_W];
    endfunction

    function automatic logic [4:0] skew_field(input logic [95:0] w, input int idx);
        skew_field = w[CCW_SKEW_HI_BIT - CCW_SKEW_W*idx -: CCW_SKEW_W];
    endfunction

    function automatic ccw_inif_t inif_field(input logic [95:0] w, input int idx);
        inif_field = ccw_inif_t'(w[CCW_INIF_HI_BIT - CCW_INIF_W*idx -: CCW_INIF_W]);
    endfunction

    // load sequencing
    typedef enum logic [1:0] {
        CCW_ST_IDLE  = 2'b00,
        CCW_ST_SHIFT = 2'b01,
        CCW_ST_ERR   = 2'b10
    } ccw_state_t;

    ccw_state_t  state_r;
    ccw_state_t  state_nxt;
    logic [95:0] shift_r;
    logic [6:0]  bit_cnt_r;
    logic [95:0] word_r;
    logic        error_r;
    logic [4:0]  dis_pin_meta_r;
    logic [4:0]  dis_pin_r;
    logic        style_meta_r;
    logic        style_r;
    logic        loop_meta_r;
    logic        loop_r;
    logic [95:0] word_nxt;

    // registered decodes of the applied word
    logic        lvl25_r;
    logic        vco_hi_r;
    logic        rise_r;
    logic        bypass_r;
    logic        rsvd_r;
    logic [3:0]  ratio_r;
    logic        ratio_rsvd_r;
    ccw_inif_t   reference_input_zero_if_r;
    ccw_inif_t   reference_input_one_if_r;
    ccw_inif_t   fb_if_r;

    // decode helpers feeding those registers
    logic [3:0]  fbn_ratio_w;
    logic        fbn_rsvd_w;
    logic        gated_style;
    ccw_bank_ctl_t [5:0] bank_ctl_nxt;
    ccw_bank_ctl_t [5:0] bank_ctl_r;

    localparam logic [6:0] FULL_CNT = 7'(WORD_W);

    // sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            CCW_ST_IDLE:
            begin
                if (ser_in.load_start)
                    state_nxt = CCW_ST_SHIFT;
            end
            CCW_ST_SHIFT:
            begin
                if (ser_in.load_done)
                    state_nxt = (bit_cnt_r == FULL_CNT) ? CCW_ST_IDLE : CCW_ST_ERR;
            end
            CCW_ST_ERR:
            begin
                if (ser_in.load_start)
                    state_nxt = CCW_ST_SHIFT;
            end
            default: state_nxt = CCW_ST_IDLE;
        endcase
    end

    // sequencer state register
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            state_r <= CCW_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // shift register and bit counter, shifted msb first
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            shift_r   <= CCW_RESET_WORD;
            bit_cnt_r <= 7'h00;
        end
        else if (ser_in.load_start)
        begin
            shift_r   <= word_r;   // preload so readback shifts out the applied word
            bit_cnt_r <= 7'h00;
        end
        else if (state_r == CCW_ST_SHIFT && ser_in.shift_en)
        begin
            shift_r <= {shift_r[94:0], ser_in.shift_bit};
            if (bit_cnt_r != 7'h7f)
                bit_cnt_r <= bit_cnt_r + 7'h01;
        end
    end

    // next applied word: only a complete load replaces it
    // reset forces the reset word here too, so the decode registers follow it
    always_comb
    begin
        word_nxt = word_r;
        if (!rst_n)
            word_nxt = CCW_RESET_WORD;
        else if (state_r == CCW_ST_SHIFT && ser_in.load_done && bit_cnt_r == FULL_CNT)
            word_nxt = shift_r;
    end

    // applied word, partial shifts never reach it
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            word_r <= CCW_RESET_WORD;
        else
            word_r <= word_nxt;
    end

    // short or long load flag, cleared by the next start
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            error_r <= 1'b0;
        else if (state_r == CCW_ST_SHIFT && ser_in.load_done)
            error_r <= (bit_cnt_r != FULL_CNT);
        else if (ser_in.load_start)
            error_r <= 1'b0;
    end

    // pin synchronisers
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            dis_pin_meta_r <= 5'h1f;
            dis_pin_r      <= 5'h1f;
            style_meta_r   <= 1'b0;
            style_r        <= 1'b0;
            loop_meta_r    <= 1'b0;
            loop_r         <= 1'b0;
        end
        else
        begin
            dis_pin_meta_r <= bank_output_disable;
            dis_pin_r      <= dis_pin_meta_r;
            style_meta_r   <= disable_style_select;
            style_r        <= style_meta_r;
            loop_meta_r    <= loop_enable_pin;
            loop_r         <= loop_meta_r;
        end
    end

    // serial readback and status
    assign ser_out                  = shift_r[95];
    assign load_error               = error_r;
    assign clock_configuration_word = word_r;

    // decoded outputs straight from their registers
    assign ctrl_pin_lvl_25         = lvl25_r;
    assign vco_band_high           = vco_hi_r;
    assign sync_rising_edge        = rise_r;
    assign loop_bypass             = bypass_r;
    assign reserved_nonzero        = rsvd_r;
    assign fb_divide_ratio         = ratio_r;
    assign fb_divide_reserved      = ratio_rsvd_r;
    assign reference_input_zero_if = reference_input_zero_if_r;
    assign reference_input_one_if  = reference_input_one_if_r;
    assign feedback_input_if       = fb_if_r;
    assign bank_clock_output_ctl   = bank_ctl_r;

    // feedback divider decode of the next word
    ccw_fbdiv_dec u_fbdiv
    (
        .fbn_code     (word_nxt[CCW_FBN_LO +: CCW_FBN_W]),
        .fbn_ratio    (fbn_ratio_w),
        .fbn_reserved (fbn_rsvd_w)
    );

    // style pin or bit 59 high gates disabled banks instead of floating them
    assign gated_style = style_r | word_nxt[CCW_DIS_STYLE_BIT];

    for (genvar b = 0; b < CCW_NUM_OUTS; b++)
    begin : g_bank
        ccw_skew_t skew_mode;
        logic      disabled;

        ccw_skew_dec u_skew
        (
            .skew_code (skew_field(word_nxt, b)),
            .skew_mode (skew_mode)
        );

        if (b < CCW_NUM_BANKS)
        begin : g_out
            // bit and pin both low to run
            assign disabled = word_nxt[CCW_DIS_HI_BIT - b] | dis_pin_r[b];
        end
        else
        begin : g_fb
            assign disabled = 1'b0;  // feedback bank has no disable control
        end

        // next controls of this bank
        always_comb
        begin
            bank_ctl_nxt[b].run       = ~disabled;
            bank_ctl_nxt[b].tristate  = disabled & ~gated_style;
            bank_ctl_nxt[b].stop_true = ~word_nxt[CCW_EDGE_BIT];
            bank_ctl_nxt[b].stop_comp = word_nxt[CCW_EDGE_BIT];
            bank_ctl_nxt[b].level     = lvl_field(word_nxt, b);
            bank_ctl_nxt[b].skew      = skew_mode;
        end
    end

    // global controls, loaded from the next word so they change with the applied word
    // either the loop bit or the synced pin high bypasses the loop
    always_ff @(posedge mclk)
    begin
        lvl25_r  <= word_nxt[CCW_CTRL_LVL_BIT];
        vco_hi_r <= word_nxt[CCW_VCO_BAND_BIT];
        rise_r   <= word_nxt[CCW_EDGE_BIT];
        bypass_r <= word_nxt[CCW_LOOP_EN_BIT] | loop_r;
        rsvd_r   <= |word_nxt[CCW_RSVD_HI:CCW_RSVD_LO];
    end

    // divide and input interface fields, same timing as the word
    always_ff @(posedge mclk)
    begin
        ratio_r      <= fbn_ratio_w;
        ratio_rsvd_r <= fbn_rsvd_w;
        reference_input_zero_if_r    <= inif_field(word_nxt, 0);
        reference_input_one_if_r    <= inif_field(word_nxt, 1);
        fb_if_r      <= inif_field(word_nxt, 2);
    end

    // bank controls; the pin part lags the pins by three edges
    always_ff @(posedge mclk)
    begin
        bank_ctl_r <= bank_ctl_nxt;
    end

endmodule
`default_nettype wire

// >>> rtl/ccw_fbdiv_dec.sv
// feedback divide-by-n code decoder
`timescale 1ns/10ps
`default_nettype none
module ccw_fbdiv_dec
    import ccw_pkg::*;
(
    // raw code
    input  wire logic [3:0] fbn_code,
    // decoded ratio and legality
    output logic      [3:0] fbn_ratio,
    output logic            fbn_reserved
);
    // ascending codes map to 1-6, 8, 10, 12
    always_comb
    begin
        fbn_reserved = 1'b0;
        case (fbn_code)
            4'h0:    fbn_ratio = 4'h1;
            4'h1:    fbn_ratio = 4'h2;
            4'h2:    fbn_ratio = 4'h3;
            4'h3:    fbn_ratio = 4'h4;
            4'h4:    fbn_ratio = 4'h5;
            4'h5:    fbn_ratio = 4'h6;
            4'h6:    fbn_ratio = 4'h8;
            4'h7:    fbn_ratio = 4'ha;
            4'h8:    fbn_ratio = 4'hc;
            default:
            begin
                fbn_ratio    = 4'h1;   // reserved code, hold at unity
                fbn_reserved = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> rtl/ccw_pkg.sv
// package: configuration word layout, field decodes and carriers for the clock driver config block
package ccw_pkg;

    // word geometry
    localparam int CCW_WORD_W        = 96;
    localparam int CCW_RSVD_HI       = 95;
    localparam int CCW_RSVD_LO       = 62;
    // control-pin level, vco band, disable style, sync edge, loop enable
    localparam int CCW_CTRL_LVL_BIT  = 61;
    localparam int CCW_VCO_BAND_BIT  = 60;
    localparam int CCW_DIS_STYLE_BIT = 59;
    localparam int CCW_EDGE_BIT      = 58;
    localparam int CCW_LOOP_EN_BIT   = 57;
    // bank disable bits: bank 1 at 56 down to bank 5 at 52
    localparam int CCW_DIS_HI_BIT    = 56;
    localparam int CCW_NUM_BANKS     = 5;
    // feedback divide-by-n code
    localparam int CCW_FBN_LO        = 48;
    localparam int CCW_FBN_W         = 4;
    // output level fields: bank 1 at 47:46 ... feedback at 37:36
    localparam int CCW_LVL_HI_BIT    = 47;
    localparam int CCW_LVL_W         = 2;
    // input interface fields: reference_input_zero 35:34, reference_input_one 33:32, feedback 31:30
    localparam int CCW_INIF_HI_BIT   = 35;
    localparam int CCW_INIF_W        = 2;
    localparam int CCW_NUM_INPUTS    = 3;
    // skew fields: bank 1 at 29:25 ... feedback at 4:0
    localparam int CCW_SKEW_HI_BIT   = 29;
    localparam int CCW_SKEW_W        = 5;
    localparam int CCW_NUM_OUTS      = 6;

    // reset value of the whole word
    localparam logic [95:0] CCW_RESET_WORD = 96'h0;

    // skew codes
    localparam logic [4:0] CCW_SKEW_ZERO = 5'h00;
    localparam logic [4:0] CCW_SKEW_INV  = 5'h10;
    localparam logic [4:0] CCW_SKEW_DIV2 = 5'h11;
    localparam logic [4:0] CCW_SKEW_DIV4 = 5'h12;

    // highest legal feedback divide code
    localparam logic [3:0] CCW_FBN_MAX_CODE = 4'h8;

    // decoded skew mode per output
    typedef enum logic [1:0] {
        CCW_SK_ZERO = 2'b00,
        CCW_SK_INV  = 2'b01,
        CCW_SK_DIV2 = 2'b10,
        CCW_SK_DIV4 = 2'b11
    } ccw_skew_t;

    // decoded input interface
    typedef enum logic [1:0] {
        CCW_IN_DIFF  = 2'b00,
        CCW_IN_SE25  = 2'b01,
        CCW_IN_RSVD  = 2'b10,
        CCW_IN_SE18  = 2'b11
    } ccw_inif_t;

    // serial load port
    typedef struct packed {
        logic load_start;
        logic shift_en;
        logic shift_bit;
        logic load_done;
    } ccw_serial_t;

    // per-bank output control
    typedef struct packed {
        logic      run;
        logic      tristate;
        logic      stop_true;
        logic      stop_comp;
        logic [1:0] level;
        ccw_skew_t skew;
    } ccw_bank_ctl_t;

endpackage

// >>> rtl/ccw_skew_dec.sv
// skew/divide field decoder for one output bank
`timescale 1ns/10ps
`default_nettype none
module ccw_skew_dec
    import ccw_pkg::*;
(
    // raw field
    input  wire logic [4:0] skew_code,
    // decoded mode
    output var ccw_pkg::ccw_skew_t skew_mode
);
    // unlisted codes fall back to zero skew
    always_comb
    begin
        case (skew_code)
            CCW_SKEW_INV:  skew_mode = CCW_SK_INV;
            CCW_SKEW_DIV2: skew_mode = CCW_SK_DIV2;
            CCW_SKEW_DIV4: skew_mode = CCW_SK_DIV4;
            default:       skew_mode = CCW_SK_ZERO;
        endcase
    end
endmodule
`default_nettype wire

// >>> testbench/ccw_config_word_assertions.sv
// port checks of the configuration word block
`timescale 1ns/10ps
`default_nettype none
module ccw_config_word_checker
    import ccw_pkg::*;
(
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire ccw_pkg::ccw_serial_t        ser_in,
    input wire logic                        disable_style_select,
    input wire logic [4:0]                  bank_output_disable,
    input wire logic                        loop_enable_pin,
    input wire logic [95:0]                 clock_configuration_word,
    input wire logic                        ctrl_pin_lvl_25,
    input wire logic                        vco_band_high,
    input wire logic                        sync_rising_edge,
    input wire logic                        loop_bypass,
    input wire logic                        fb_divide_reserved,
    input wire ccw_pkg::ccw_inif_t          reference_input_zero_if,
    input wire ccw_pkg::ccw_bank_ctl_t [5:0] bank_clock_output_ctl
);
    logic [1:0] up_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // cycles since reset release, saturating
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    end
    a_ctrl_level: assert property (ctrl_pin_lvl_25 == clock_configuration_word[61])
        else $error("control level wrong");
    a_vco_band: assert property (vco_band_high == clock_configuration_word[60])
        else $error("vco band wrong");
    a_sync_edge: assert property (sync_rising_edge == clock_configuration_word[58])
        else $error("sync edge wrong");
    a_word_hold: assert property (!$stable(clock_configuration_word) |->
        $past(ser_in.load_done) || $past(ser_in.load_done, 2)) else $error("word changed without load");
    a_bank_run: assert property (up_r == 2'h3 |-> bank_clock_output_ctl[0].run ==
        !(clock_configuration_word[56] | $past(bank_output_disable[0], 3))) else $error("bank run wrong");
    a_gate_style: assert property (up_r == 2'h3 && !bank_clock_output_ctl[4].run |->
        bank_clock_output_ctl[4].tristate == !(clock_configuration_word[59] | $past(disable_style_select, 3)))
        else $error("disable style wrong");
    a_loop_bypass: assert property (up_r == 2'h3 |->
        loop_bypass == (clock_configuration_word[57] | $past(loop_enable_pin, 3))) else $error("bypass wrong");
    a_stop_level: assert property (bank_clock_output_ctl[5].stop_true != clock_configuration_word[58]
        && bank_clock_output_ctl[5].stop_comp == clock_configuration_word[58]) else $error("stop level wrong");
    a_fb_resv: assert property (fb_divide_reserved == (clock_configuration_word[51:48] > 4'h8))
        else $error("reserved divide flag wrong");
    a_ref_zero: assert property (reference_input_zero_if == clock_configuration_word[35:34])
        else $error("input interface wrong");
    a_out_level: assert property (bank_clock_output_ctl[5].level == clock_configuration_word[37:36]
        && bank_clock_output_ctl[0].level == clock_configuration_word[47:46]) else $error("level wrong");
    a_skew_div2: assert property (clock_configuration_word[9:5] == 5'h11 |->
        bank_clock_output_ctl[4].skew == CCW_SK_DIV2) else $error("skew decode wrong");
    // main scenarios
    c_load: cover property (ser_in.load_done ##[1:2] $changed(clock_configuration_word));
    c_tri: cover property (!bank_clock_output_ctl[4].run && bank_clock_output_ctl[4].tristate);
    c_resv: cover property (fb_divide_reserved);
endmodule
bind ccw_config_word ccw_config_word_checker ccw_config_word_checker_inst (.mclk, .rst_n, .ser_in,
    .disable_style_select, .bank_output_disable, .loop_enable_pin, .clock_configuration_word,
    .ctrl_pin_lvl_25, .vco_band_high, .sync_rising_edge, .loop_bypass, .fb_divide_reserved,
    .reference_input_zero_if, .bank_clock_output_ctl);
`default_nettype wire

// >>> testbench/ccw_host_model.sv
// host model that loads the configuration word over the serial port
`timescale 1ns/10ps
`default_nettype none
module ccw_host_model
    import ccw_pkg::*;
(
    // clock
    input  wire logic            mclk,
    // readback from the block
    input  wire logic            ser_rd,
    // serial load port toward the block
    output var ccw_pkg::ccw_serial_t ser
);
    logic [95:0] readback;  // applied word as shifted out during the last load
    initial ser = '0;
    // start, n bits msb first, then done
    task automatic load(input logic [95:0] w, input int n);
        logic [95:0] v;
        v = {34'h0, w[61:0]};
        @(negedge mclk);
        ser.load_start = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(negedge mclk);
            readback = {readback[94:0], ser_rd};  // msb first
            ser.load_start = 1'b0;
            ser.shift_en = 1'b1;
            ser.shift_bit = v[95 - (i % 96)];
        end
        @(negedge mclk);
        ser = {3'b000, 1'b1};
        @(negedge mclk);
        ser.load_done = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the configuration word block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
    import ccw_pkg::*;
    logic                 mclk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 style = 1'b0;
    logic [4:0]           dis = 5'h00;
    logic                 loop_pin = 1'b0;
    ccw_serial_t          ser;
    logic                 ser_out, load_error, lvl25, vco_hi, rise, bypass, rsv_nz, fb_rsv;
    logic [95:0]          word;
    logic [3:0]           ratio;
    ccw_inif_t            if0, if1, fbif;
    ccw_bank_ctl_t [5:0]  ctl;
    logic [4:0]           sk [5] = '{5'h00, 5'h10, 5'h11, 5'h12, 5'h07};
    int                   fail_count = 0;
    int                   n_compared = 0;
    always #2.5 mclk = ~mclk;
    ccw_host_model ccw_host_model_inst (.mclk(mclk), .ser_rd(ser_out), .ser(ser));
    ccw_config_word ccw_config_word_inst (.mclk(mclk), .rst_n(rst_n), .ser_in(ser), .ser_out(ser_out),
        .load_error(load_error), .disable_style_select(style), .bank_output_disable(dis),
        .loop_enable_pin(loop_pin), .clock_configuration_word(word), .ctrl_pin_lvl_25(lvl25),
        .vco_band_high(vco_hi), .sync_rising_edge(rise), .loop_bypass(bypass), .reserved_nonzero(rsv_nz),
        .fb_divide_ratio(ratio), .fb_divide_reserved(fb_rsv), .reference_input_zero_if(if0),
        .reference_input_one_if(if1), .feedback_input_if(fbif), .bank_clock_output_ctl(ctl));
    // expected divide ratio, reserved codes read as one
    function automatic logic [3:0] f_ratio(input logic [3:0] c);
        logic [3:0] t [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'ha, 4'hc};
        return (c > 4'h8) ? 4'h1 : t[c];
    endfunction
    // expected skew mode
    function automatic ccw_skew_t f_skew(input logic [4:0] c);
        return (c == 5'h10) ? CCW_SK_INV : (c == 5'h11) ? CCW_SK_DIV2 : (c == 5'h12) ? CCW_SK_DIV4 : CCW_SK_ZERO;
    endfunction
    // load through the host, then let the apply edge pass
    task automatic put(input logic [95:0] w, input int n);
        ccw_host_model_inst.load(w, n);
        @(negedge mclk);
    endtask
    // all decodes of an applied word except the loop bypass
    task automatic check_word(input logic [95:0] w);
        `CHK(word, w)
        `CHK(lvl25, w[61])
        `CHK(vco_hi, w[60])
        `CHK(rise, w[58])
        `CHK(ratio, f_ratio(w[51:48]))
        `CHK(fb_rsv, w[51:48] > 4'h8)
        `CHK(if0, w[35:34])
        `CHK(if1, w[33:32])
        `CHK(fbif, w[31:30])
        `CHK(rsv_nz, 1'b0)
        for (int i = 0; i < 6; i++)
        begin
            `CHK(ctl[i].run, (i < 5) ? !(w[56 - i] | dis[i]) : 1'b1)
            `CHK(ctl[i].tristate, (i < 5) ? ((w[56 - i] | dis[i]) & !(w[59] | style)) : 1'b0)
            `CHK(ctl[i].level, w[47 - 2 * i -: 2])
            `CHK(ctl[i].skew, f_skew(w[29 - 5 * i -: 5]))
            `CHK({ctl[i].stop_true, ctl[i].stop_comp}, {!w[58], w[58]})
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d, failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard
    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        logic [95:0] w;
        logic [95:0] exp_w;
        logic [95:0] prev_w;
        void'($urandom(32'hb0be18ab));
        prev_w = 96'h0;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK(word, 96'h0)
        // every divide code, skew corners on bank one
        for (int c = 0; c < 16; c++)
        begin
            w = {$urandom, $urandom, $urandom};
            w[51:48] = c[3:0];
            w[29:25] = sk[c % 5];
            exp_w = {34'h0, w[61:0]};
            put(w, 96);
            `CHK(load_error, 1'b0)
            `CHK(ccw_host_model_inst.readback, prev_w)
            check_word(exp_w);
            prev_w = exp_w;
        end
        // a short load is refused and the old word stays
        put({$urandom, $urandom, $urandom}, 95);
        `CHK(load_error, 1'b1)
        `CHK(ccw_host_model_inst.readback[94:0], exp_w[95:1])
        check_word(exp_w);
        // bank one disable pin, style pin and style bit in every combination, bank five held off by its bit
        for (int i = 0; i < 8; i++)
        begin
            w = 96'h0;
            w[59] = i[1];
            w[57] = i[2];
            w[52] = 1'b1;
            style = i[0];
            dis[0] = i[2];
            loop_pin = i[0];
            put(w, 96);
            repeat (2) @(negedge mclk);
            `CHK(ctl[0].run, !i[2])
            `CHK(ctl[4].run, 1'b0)
            `CHK(ctl[4].tristate, !(i[0] | i[1]))
            `CHK(bypass, i[0] | i[2])
        end
        print_verdict();
    end
endmodule
`default_nettype wire
